//--- rtl/beh_pkg.sv
// shared constants for the bus error response block
package beh_pkg;
   // ==========================================================
   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int STAT_W = 3;
   localparam int PRIV_W = 4;
   localparam int MSTR_W = 8;
   localparam int NUM_PRIV = 16;
   localparam int ROUTE_FLD_W = 2;
   localparam int NUM_CORES = 4;
   // ==========================================================
   // response source codes on RESP_SRC_IN
   localparam logic [2:0] SRC_DSP = 3'h0;
   localparam logic [2:0] SRC_APP = 3'h1;
   localparam logic [2:0] SRC_PCIE = 3'h2;
   localparam logic [2:0] SRC_DMA = 3'h3;
   localparam logic [2:0] SRC_PKT = 3'h4;
   localparam logic [2:0] SRC_TELECOM_SERIAL_PORT = 3'h5;
   localparam logic [2:0] SRC_SERIAL_INTERCONNECT_PORT = 3'h6;
   localparam logic [2:0] SRC_LINK = 3'h7;
   // ==========================================================
   // codes, reset values and field positions
   localparam logic [STAT_W-1:0] DSP_STAT_CODE = 3'h4;
   localparam logic ABORT_MASK_RESET = 1'b1;
   localparam int CAPT_VALID_BIT = 31;
   localparam int CAPT_DIR_BIT = 3;
   localparam int QUEUE_NONEMPTY_BIT = 31;
   localparam int CTRL_BIT = 0;
   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_DSP_CAPT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FAULT_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DATA_FAULT_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INSTR_FAULT_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_AUX_FAULT_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_DATA_FAULT_ADDR = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_DMA_BUS_ERR = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_DMA_ERR_DETAIL = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_DMA_CTRL = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_COND_STATUS = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_CAPT_LO = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_CAPT_HI = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_COND_ROUTE = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_LINK_CTRL = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_QUEUE_BASE = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_QUEUE_STRIDE = 8'h04;
endpackage

//--- rtl/beh_err_queue.sv
// per-channel queue of error codes for the telecom serial port
`timescale 1ns/1ps
`default_nettype none
module beh_err_queue #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 3
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic push_in,
   input wire logic [WIDTH-1:0] push_data_in,
   input wire logic pop_in,
   output logic [WIDTH-1:0] head_out,
   output logic empty_out,
   output logic push_ok_out
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [PTR_W:0] count;
   } beh_queue_t;
   beh_queue_t st;
   beh_queue_t next_st;
   logic pop_ok;

   // a full queue drops the new code and raises no event
   assign push_ok_out = push_in && (st.count != FULL_COUNT);
   assign pop_ok = pop_in && (st.count != '0);
   assign head_out = st.mem[st.rd_ptr];
   assign empty_out = (st.count == '0);

   always_comb begin
      next_st = st;
      if (push_ok_out) begin
         next_st.mem[st.wr_ptr] = push_data_in;
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      if (pop_ok) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      next_st.count = st.count + (PTR_W + 1)'(push_ok_out) - (PTR_W + 1)'(pop_ok);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_push_stored;
      push_ok_out && !pop_ok && empty_out |=> !empty_out && head_out == $past(push_data_in);
   endproperty
   a_push_stored: assert property (p_push_stored) else $error("queued code lost");

   property p_count_bound;
      st.count <= FULL_COUNT;
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("queue count overflow");
endmodule
`default_nettype wire

//--- rtl/beh_bus_error_top.sv
// bus error response handling for the on-chip masters, with register slave
`timescale 1ns/1ps
`default_nettype none
module beh_bus_error_top #(
   parameter int TELECOM_SERIAL_PORT_CHANNELS = 4,
   parameter int TELECOM_SERIAL_PORT_DEPTH = 4,
   localparam int CH_W = $clog2(TELECOM_SERIAL_PORT_CHANNELS)
) (
   input wire logic CLK_SYS_IN,
   input wire logic RST_N_IN,
   input wire logic [beh_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [beh_pkg::DATA_W-1:0] AVS_WRITEDATA_IN,
   input wire logic [beh_pkg::BE_W-1:0] AVS_BYTEENABLE_IN,
   output logic [beh_pkg::DATA_W-1:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic RESP_VALID_IN,
   input wire logic [2:0] RESP_SRC_IN,
   input wire logic RESP_READ_IN,
   input wire logic RESP_FETCH_IN,
   input wire logic [beh_pkg::STAT_W-1:0] RESP_STATUS_IN,
   input wire logic [beh_pkg::DATA_W-1:0] RESP_ADDR_IN,
   input wire logic [beh_pkg::PRIV_W-1:0] RESP_PRIV_IN,
   input wire logic [beh_pkg::MSTR_W-1:0] RESP_MSTR_IN,
   input wire logic [CH_W-1:0] RESP_CHAN_IN,
   input wire logic LINK_ACTIVE_IN,
   output logic DSP_DMA_ERR_IRQ_OUT,
   output logic APP_ABORT_OUT,
   output logic PCIE_CPL_ABORT_OUT,
   output logic DMA_ERR_IRQ_OUT,
   output logic DMA_BEAT_DONE_OUT,
   output logic [TELECOM_SERIAL_PORT_CHANNELS-1:0] TELECOM_SERIAL_PORT_ERR_EVT_OUT,
   output logic [beh_pkg::NUM_CORES-1:0] SERIAL_INTERCONNECT_PORT_CORE_IRQ_OUT,
   output logic LINK_RVALID_OUT,
   output logic [beh_pkg::STAT_W-1:0] LINK_RSTATUS_OUT,
   output logic LINK_ERR_IRQ_OUT,
   output logic LINK_USER_IRQ_OUT
);
   import beh_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic wait_req;
      logic [DATA_W-1:0] rdata;
      logic dsp_valid;
      logic [STAT_W-1:0] dsp_stat;
      logic dsp_irq;
      logic abort_mask;
      logic abort_pend;
      logic abort;
      logic [STAT_W-1:0] dfs;
      logic [STAT_W-1:0] ifs;
      logic [STAT_W-1:0] adfs;
      logic [DATA_W-1:0] dfa;
      logic pcie_abort;
      logic dma_valid;
      logic dma_read;
      logic [STAT_W-1:0] dma_stat;
      logic [DATA_W-1:0] dma_detail;
      logic dma_irq_en;
      logic dma_irq;
      logic dma_beat;
      logic [NUM_PRIV-1:0] icsr;
      logic [DATA_W-1:0] capt_lo;
      logic [PRIV_W+MSTR_W-1:0] capt_hi;
      logic [NUM_PRIV*ROUTE_FLD_W-1:0] route;
      logic [NUM_CORES-1:0] serial_interconnect_port_irq;
      logic link_sel;
      logic link_rvalid;
      logic [STAT_W-1:0] link_rstat;
      logic link_int;
      logic link_user;
      logic [TELECOM_SERIAL_PORT_CHANNELS-1:0] telecom_serial_port_evt;
   } beh_state_t;

   localparam beh_state_t ST_RESET = '{wait_req: 1'b1, abort_mask: ABORT_MASK_RESET,
                                       default: '0};

   beh_state_t st;
   beh_state_t next_st;
   logic acc;
   logic resp_err;
   logic [DATA_W-1:0] clr_mask;
   logic [TELECOM_SERIAL_PORT_CHANNELS-1:0] q_push;
   logic [TELECOM_SERIAL_PORT_CHANNELS-1:0] q_pop;
   logic [TELECOM_SERIAL_PORT_CHANNELS-1:0] q_push_ok;
   logic [TELECOM_SERIAL_PORT_CHANNELS-1:0] q_empty;
   logic [TELECOM_SERIAL_PORT_CHANNELS-1:0][STAT_W-1:0] q_head;

   // byte-lane merge of a write into an existing register value
   function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] wd,
                                                input logic [BE_W-1:0] be);
      logic [DATA_W-1:0] res;
      res = old;
      for (int b = 0; b < BE_W; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // control bit of a register after a byte-lane write
   function automatic logic wbit(input logic old,
                                 input logic [DATA_W-1:0] wd,
                                 input logic [BE_W-1:0] be);
      logic [DATA_W-1:0] res;
      res = wmerge(DATA_W'(old), wd, be);
      return res[CTRL_BIT];
   endfunction

   // ==========================================================
   // telecom serial port channel queues
   assign resp_err = RESP_VALID_IN && (RESP_STATUS_IN != '0);

   for (genvar c = 0; c < TELECOM_SERIAL_PORT_CHANNELS; c++) begin : g_queue
      assign q_push[c] = resp_err && (RESP_SRC_IN == SRC_TELECOM_SERIAL_PORT) &&
                         (RESP_CHAN_IN == CH_W'(c));
      beh_err_queue #(
         .DEPTH(TELECOM_SERIAL_PORT_DEPTH),
         .WIDTH(STAT_W)
      ) u_queue (
         .clk_in(CLK_SYS_IN),
         .rst_n_in(RST_N_IN),
         .push_in(q_push[c]),
         .push_data_in(RESP_STATUS_IN),
         .pop_in(q_pop[c]),
         .head_out(q_head[c]),
         .empty_out(q_empty[c]),
         .push_ok_out(q_push_ok[c])
      );
   end

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      q_pop = '0;
      clr_mask = wmerge('0, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
      // one answer per request: accept only while waitrequest stands high
      acc = st.wait_req && (AVS_READ_IN || AVS_WRITE_IN);
      next_st.wait_req = !acc;
      next_st.abort = 1'b0;
      next_st.pcie_abort = 1'b0;
      next_st.dma_beat = 1'b0;
      next_st.link_rvalid = 1'b0;
      next_st.link_int = 1'b0;
      next_st.link_user = 1'b0;

      if (acc && AVS_READ_IN) begin
         next_st.rdata = '0;
         case (AVS_ADDRESS_IN)
            OFS_DSP_CAPT: next_st.rdata[STAT_W-1:0] = st.dsp_stat;
            OFS_FAULT_CTRL: next_st.rdata[CTRL_BIT] = st.abort_mask;
            OFS_DATA_FAULT_STATUS: next_st.rdata[STAT_W-1:0] = st.dfs;
            OFS_INSTR_FAULT_STATUS: next_st.rdata[STAT_W-1:0] = st.ifs;
            OFS_AUX_FAULT_STATUS: next_st.rdata[STAT_W-1:0] = st.adfs;
            OFS_DATA_FAULT_ADDR: next_st.rdata = st.dfa;
            OFS_DMA_BUS_ERR: begin
               next_st.rdata[STAT_W-1:0] = st.dma_stat;
               next_st.rdata[CAPT_DIR_BIT] = st.dma_read;
               next_st.rdata[CAPT_VALID_BIT] = st.dma_valid;
            end
            OFS_DMA_ERR_DETAIL: next_st.rdata = st.dma_detail;
            OFS_DMA_CTRL: next_st.rdata[CTRL_BIT] = st.dma_irq_en;
            OFS_COND_STATUS: next_st.rdata[NUM_PRIV-1:0] = st.icsr;
            OFS_CAPT_LO: next_st.rdata = st.capt_lo;
            OFS_CAPT_HI: next_st.rdata[PRIV_W+MSTR_W-1:0] = st.capt_hi;
            OFS_COND_ROUTE: next_st.rdata = st.route;
            OFS_LINK_CTRL: next_st.rdata[CTRL_BIT] = st.link_sel;
            default: next_st.rdata = '0;
         endcase
         // reading a queue window pops its head code
         for (int c = 0; c < TELECOM_SERIAL_PORT_CHANNELS; c++) begin
            if (AVS_ADDRESS_IN == OFS_QUEUE_BASE + ADDR_W'(c) * OFS_QUEUE_STRIDE) begin
               next_st.rdata[STAT_W-1:0] = q_head[c];
               next_st.rdata[QUEUE_NONEMPTY_BIT] = !q_empty[c];
               q_pop[c] = 1'b1;
            end
         end
      end

      // a write lands at the edge where the master sees waitrequest low
      if (!st.wait_req && AVS_WRITE_IN) begin
         case (AVS_ADDRESS_IN)
            OFS_DSP_CAPT: begin
               next_st.dsp_valid = 1'b0;
               next_st.dsp_stat = '0;
               next_st.dsp_irq = 1'b0;
            end
            OFS_FAULT_CTRL:
               next_st.abort_mask = wbit(st.abort_mask, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            OFS_DMA_BUS_ERR: begin
               next_st.dma_valid = 1'b0;
               next_st.dma_stat = '0;
               next_st.dma_read = 1'b0;
               next_st.dma_irq = 1'b0;
            end
            OFS_DMA_CTRL:
               next_st.dma_irq_en = wbit(st.dma_irq_en, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            OFS_COND_STATUS: next_st.icsr = st.icsr & ~clr_mask[NUM_PRIV-1:0];
            OFS_COND_ROUTE: next_st.route = wmerge(st.route, AVS_WRITEDATA_IN,
                                                   AVS_BYTEENABLE_IN);
            OFS_LINK_CTRL:
               next_st.link_sel = wbit(st.link_sel, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            default: ;
         endcase
      end

      // a pending asynchronous abort is taken once software unmasks it
      if (st.abort_pend && !st.abort_mask) begin
         next_st.abort = 1'b1;
         next_st.abort_pend = 1'b0;
      end

      // hardware events come last so a set beats a same-cycle clear, except dsp and dma captures while their old valid bit is set
      if (resp_err) begin
         unique case (RESP_SRC_IN)
            SRC_DSP: begin
               if (!st.dsp_valid) begin
                  next_st.dsp_valid = 1'b1;
                  next_st.dsp_stat = DSP_STAT_CODE;
               end
               next_st.dsp_irq = 1'b1;
            end
            SRC_APP: begin
               if (RESP_READ_IN) begin
                  if (RESP_FETCH_IN) begin
                     next_st.ifs = RESP_STATUS_IN;
                  end else begin
                     next_st.dfs = RESP_STATUS_IN;
                  end
                  next_st.dfa = RESP_ADDR_IN;
                  next_st.abort = 1'b1;
               end else begin
                  next_st.adfs = RESP_STATUS_IN;
                  next_st.abort_pend = 1'b1;
               end
            end
            SRC_PCIE: next_st.pcie_abort = RESP_READ_IN;
            SRC_DMA: begin
               if (!st.dma_valid) begin
                  next_st.dma_valid = 1'b1;
                  next_st.dma_stat = RESP_STATUS_IN;
                  next_st.dma_read = RESP_READ_IN;
                  next_st.dma_detail = RESP_ADDR_IN;
               end
               if (st.dma_irq_en) begin
                  next_st.dma_irq = 1'b1;
               end
            end
            SRC_PKT: ;
            SRC_TELECOM_SERIAL_PORT: ;
            SRC_SERIAL_INTERCONNECT_PORT: begin
               next_st.icsr[RESP_PRIV_IN] = 1'b1;
               if (RESP_READ_IN) begin
                  next_st.capt_lo = RESP_ADDR_IN;
                  next_st.capt_hi = {RESP_PRIV_IN, RESP_MSTR_IN};
               end
            end
            SRC_LINK: begin
               if (st.link_sel) begin
                  next_st.link_user = 1'b1;
               end else begin
                  next_st.link_int = 1'b1;
               end
            end
         endcase
      end

      // the transfer goes on whatever status came back
      next_st.dma_beat = RESP_VALID_IN && (RESP_SRC_IN == SRC_DMA);
      if (RESP_VALID_IN && RESP_READ_IN && (RESP_SRC_IN == SRC_LINK) && LINK_ACTIVE_IN) begin
         next_st.link_rvalid = 1'b1;
         next_st.link_rstat = RESP_STATUS_IN;
      end

      for (int k = 0; k < NUM_CORES; k++) begin
         next_st.serial_interconnect_port_irq[k] = 1'b0;
         for (int p = 0; p < NUM_PRIV; p++) begin
            if (next_st.icsr[p] &&
                next_st.route[p*ROUTE_FLD_W +: ROUTE_FLD_W] == ROUTE_FLD_W'(k)) begin
               next_st.serial_interconnect_port_irq[k] = 1'b1;
            end
         end
      end
      next_st.telecom_serial_port_evt = q_push_ok;
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_N_IN) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs
   assign AVS_READDATA_OUT = st.rdata;
   assign AVS_WAITREQUEST_OUT = st.wait_req;
   assign DSP_DMA_ERR_IRQ_OUT = st.dsp_irq;
   assign APP_ABORT_OUT = st.abort;
   assign PCIE_CPL_ABORT_OUT = st.pcie_abort;
   assign DMA_ERR_IRQ_OUT = st.dma_irq;
   assign DMA_BEAT_DONE_OUT = st.dma_beat;
   assign TELECOM_SERIAL_PORT_ERR_EVT_OUT = st.telecom_serial_port_evt;
   assign SERIAL_INTERCONNECT_PORT_CORE_IRQ_OUT = st.serial_interconnect_port_irq;
   assign LINK_RVALID_OUT = st.link_rvalid;
   assign LINK_RSTATUS_OUT = st.link_rstat;
   assign LINK_ERR_IRQ_OUT = st.link_int;
   assign LINK_USER_IRQ_OUT = st.link_user;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_N_IN);

   property p_bus_answer;
      (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=>
         !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

   property p_dsp_code;
      resp_err && RESP_SRC_IN == SRC_DSP && !st.dsp_valid |=> st.dsp_stat == DSP_STAT_CODE;
   endproperty
   a_dsp_code: assert property (p_dsp_code) else $error("dsp code not captured");

   property p_dsp_irq;
      resp_err && RESP_SRC_IN == SRC_DSP |=> DSP_DMA_ERR_IRQ_OUT;
   endproperty
   a_dsp_irq: assert property (p_dsp_irq) else $error("dsp interrupt missing");

   property p_async_masked;
      st.abort_mask && !st.abort_pend && !(resp_err && RESP_SRC_IN == SRC_APP && RESP_READ_IN)
         |=> !APP_ABORT_OUT;
   endproperty
   a_async_masked: assert property (p_async_masked) else $error("masked abort taken");

   property p_sync_addr;
      resp_err && RESP_SRC_IN == SRC_APP && RESP_READ_IN |=>
         APP_ABORT_OUT && st.dfa == $past(RESP_ADDR_IN);
   endproperty
   a_sync_addr: assert property (p_sync_addr) else $error("sync abort not recorded");

   property p_pcie_abort;
      resp_err && RESP_SRC_IN == SRC_PCIE |=>
         PCIE_CPL_ABORT_OUT == $past(RESP_READ_IN) && $stable(st.icsr) && $stable(st.dma_valid);
   endproperty
   a_pcie_abort: assert property (p_pcie_abort) else $error("pcie answer wrong");

   property p_dma_gate;
      DMA_ERR_IRQ_OUT && !$past(DMA_ERR_IRQ_OUT) |-> $past(st.dma_irq_en);
   endproperty
   a_dma_gate: assert property (p_dma_gate) else $error("disabled dma interrupt");

   property p_dma_beat;
      RESP_VALID_IN && RESP_SRC_IN == SRC_DMA |=> DMA_BEAT_DONE_OUT;
   endproperty
   a_dma_beat: assert property (p_dma_beat) else $error("dma beat not completed");

   property p_pkt_silent;
      resp_err && RESP_SRC_IN == SRC_PKT && !(AVS_WRITE_IN && !st.wait_req) |=>
         $stable(st.icsr) && $stable(st.dma_valid) && $stable(st.dsp_valid);
   endproperty
   a_pkt_silent: assert property (p_pkt_silent) else $error("packet dma logged");

   property p_chan_event;
      q_push_ok[0] |=> TELECOM_SERIAL_PORT_ERR_EVT_OUT[0] ##1 !TELECOM_SERIAL_PORT_ERR_EVT_OUT[0] || $past(q_push_ok[0]);
   endproperty
   a_chan_event: assert property (p_chan_event) else $error("channel event wrong");

   property p_cond_set;
      resp_err && RESP_SRC_IN == SRC_SERIAL_INTERCONNECT_PORT |=> st.icsr[$past(RESP_PRIV_IN)];
   endproperty
   a_cond_set: assert property (p_cond_set) else $error("condition bit not set");

   property p_link_fwd;
      RESP_VALID_IN && RESP_READ_IN && RESP_SRC_IN == SRC_LINK && LINK_ACTIVE_IN |=>
         LINK_RVALID_OUT && LINK_RSTATUS_OUT == $past(RESP_STATUS_IN);
   endproperty
   a_link_fwd: assert property (p_link_fwd) else $error("link status not forwarded");
endmodule
`default_nettype wire

//--- bench/beh_slave_model.sv
// memory controller slave model that returns responses with status
`timescale 1ns/1ps
`default_nettype none
module beh_slave_model (
   input wire logic clk_in,
   output logic valid_out,
   output logic [2:0] src_out,
   output logic read_out,
   output logic fetch_out,
   output logic [beh_pkg::STAT_W-1:0] status_out,
   output logic [beh_pkg::DATA_W-1:0] addr_out,
   output logic [beh_pkg::PRIV_W-1:0] priv_out,
   output logic [beh_pkg::MSTR_W-1:0] mstr_out,
   output logic [1:0] chan_out
);
   import beh_pkg::*;
   initial begin
      valid_out = 1'b0;
      {src_out, read_out, fetch_out, status_out, addr_out, priv_out, mstr_out, chan_out} = '0;
   end
   // ==========================================
   // one response beat
   task automatic send(input logic [2:0] s, input logic r, input logic [2:0] st,
      input logic [31:0] a = 32'h0, input logic [3:0] p = 4'h0, input logic [1:0] c = 2'h0,
      input logic f = 1'b0);
      @(posedge clk_in);
      valid_out <= 1'b1;
      {src_out, read_out, fetch_out, status_out} <= {s, r, f, st};
      {addr_out, priv_out, mstr_out, chan_out} <= {a, p, p, ~p, c};
      @(posedge clk_in);
      valid_out <= 1'b0;
      // released status, address, privilege and channel lines flip so a stale value never passes for a fresh one
      {status_out, addr_out, priv_out, chan_out} <= ~{st, a, p, c};
   endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// self-checking testbench for the bus error response block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import beh_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, lact = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdat, r, ra;
   logic wreq, v, rr, ft, dsp_irq, app_ab, pcie_ab, dma_irq, beat, lrv, lerr, lusr;
   logic [2:0] src, st, lst;
   logic [3:0] pr, sirq, tev;
   logic [7:0] ms;
   logic [1:0] ch;
   logic [31:0] pc [6] = '{default: 32'h0000_0000};
   int fail_count = 0;
   int cmp_count = 0;
   always #5 clk = ~clk;
   beh_bus_error_top #(.TELECOM_SERIAL_PORT_CHANNELS(4), .TELECOM_SERIAL_PORT_DEPTH(4)) uut (
      .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
      .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .RESP_VALID_IN(v),
      .RESP_SRC_IN(src), .RESP_READ_IN(rr), .RESP_FETCH_IN(ft), .RESP_STATUS_IN(st),
      .RESP_ADDR_IN(ra), .RESP_PRIV_IN(pr), .RESP_MSTR_IN(ms), .RESP_CHAN_IN(ch),
      .LINK_ACTIVE_IN(lact), .DSP_DMA_ERR_IRQ_OUT(dsp_irq), .APP_ABORT_OUT(app_ab),
      .PCIE_CPL_ABORT_OUT(pcie_ab), .DMA_ERR_IRQ_OUT(dma_irq), .DMA_BEAT_DONE_OUT(beat),
      .TELECOM_SERIAL_PORT_ERR_EVT_OUT(tev), .SERIAL_INTERCONNECT_PORT_CORE_IRQ_OUT(sirq), .LINK_RVALID_OUT(lrv),
      .LINK_RSTATUS_OUT(lst), .LINK_ERR_IRQ_OUT(lerr), .LINK_USER_IRQ_OUT(lusr));
   beh_slave_model m (.clk_in(clk), .valid_out(v), .src_out(src), .read_out(rr),
      .fetch_out(ft), .status_out(st), .addr_out(ra), .priv_out(pr), .mstr_out(ms),
      .chan_out(ch));
   // pulse tallies; gated so pre-reset unknowns never poison them
   always @(posedge clk) begin
      if (rst_n) begin
         pc[0] <= pc[0] + app_ab;
         pc[1] <= pc[1] + pcie_ab;
         pc[2] <= pc[2] + beat;
         pc[3] <= pc[3] + tev[1];
         pc[4] <= pc[4] + lerr;
         pc[5] <= pc[5] + lusr;
      end
   end
   // ==========================================
   // shared helpers
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      do @(posedge clk); while (wreq !== 1'b0);
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_app();
      bus(1'b0, OFS_FAULT_CTRL, 32'h0);
      chk(r[0], 1'b1);
      m.send(SRC_APP, 1'b1, 3'h2, 32'h0000_1230);
      tk(2);
      chk(pc[0], 32'h1);
      bus(1'b0, OFS_DATA_FAULT_ADDR, 32'h0);
      chk(r, 32'h0000_1230);
      bus(1'b0, OFS_DATA_FAULT_STATUS, 32'h0);
      chk(r, 32'h0000_0002);
      m.send(SRC_APP, 1'b1, 3'h2, 32'h0000_2000, 4'h0, 2'h0, 1'b1);
      bus(1'b0, OFS_INSTR_FAULT_STATUS, 32'h0);
      chk(r, 32'h0000_0002);
      m.send(SRC_APP, 1'b0, 3'h2, 32'h0000_4560);
      tk(4);
      chk(pc[0], 32'h2);
      bus(1'b0, OFS_AUX_FAULT_STATUS, 32'h0);
      chk(r, 32'h0000_0002);
      bus(1'b1, OFS_FAULT_CTRL, 32'h0);
      tk(4);
      chk(pc[0], 32'h3);
      $display("test app done");
   endtask
   task automatic t_quiet();
      m.send(SRC_PCIE, 1'b1, 3'h1);
      m.send(SRC_PCIE, 1'b0, 3'h1);
      m.send(SRC_PCIE, 1'b1, 3'h0);
      m.send(SRC_PKT, 1'b1, 3'h7);
      m.send(SRC_PKT, 1'b0, 3'h7);
      tk(2);
      chk(pc[1], 32'h1);
      chk({dsp_irq, dma_irq, sirq, lerr, lusr}, 8'h00);
      bus(1'b0, OFS_COND_STATUS, 32'h0);
      chk(r, 32'h0);
      $display("test pcie and packet dma done");
   endtask
   task automatic t_dsp();
      m.send(SRC_DSP, 1'b0, 3'h3);
      m.send(SRC_DSP, 1'b1, 3'h5);
      tk(1);
      chk(dsp_irq, 1'b1);
      bus(1'b0, OFS_DSP_CAPT, 32'h0);
      chk(r[2:0], DSP_STAT_CODE);
      bus(1'b1, OFS_DSP_CAPT, 32'h0);
      tk(1);
      chk(dsp_irq, 1'b0);
      $display("test dsp done");
   endtask
   task automatic t_dma();
      bus(1'b1, OFS_DMA_CTRL, 32'h0);
      m.send(SRC_DMA, 1'b1, 3'h2, 32'h0000_0BB0);
      m.send(SRC_DMA, 1'b0, 3'h0);
      tk(2);
      chk(dma_irq, 1'b0);
      chk(pc[2], 32'h2);
      bus(1'b0, OFS_DMA_BUS_ERR, 32'h0);
      chk(r, 32'h8000_000A);
      bus(1'b0, OFS_DMA_ERR_DETAIL, 32'h0);
      chk(r, 32'h0000_0BB0);
      bus(1'b1, OFS_DMA_CTRL, 32'h1);
      m.send(SRC_DMA, 1'b0, 3'h1);
      tk(1);
      chk(dma_irq, 1'b1);
      bus(1'b1, OFS_DMA_BUS_ERR, 32'h0);
      tk(1);
      chk(dma_irq, 1'b0);
      $display("test dma done");
   endtask
   task automatic t_serial_interconnect_port();
      bus(1'b1, OFS_COND_ROUTE, 32'h0000_0080);
      m.send(SRC_SERIAL_INTERCONNECT_PORT, 1'b1, 3'h2, 32'h0000_C0C0, 4'h3);
      m.send(SRC_SERIAL_INTERCONNECT_PORT, 1'b0, 3'h2, 32'h0000_D0D0, 4'h5);
      tk(1);
      chk(sirq, 4'h5);
      bus(1'b0, OFS_COND_STATUS, 32'h0);
      chk(r, 32'h0000_0028);
      bus(1'b0, OFS_CAPT_LO, 32'h0);
      chk(r, 32'h0000_C0C0);
      bus(1'b0, OFS_CAPT_HI, 32'h0);
      chk(r, 32'h0000_033C);
      bus(1'b1, OFS_COND_STATUS, 32'h0000_0008);
      tk(1);
      chk(sirq, 4'h1);
      $display("test serial_interconnect_port done");
   endtask
   task automatic t_telecom_serial_port();
      m.send(SRC_TELECOM_SERIAL_PORT, 1'b1, 3'h6, 32'h0, 4'h0, 2'h1);
      m.send(SRC_TELECOM_SERIAL_PORT, 1'b0, 3'h3, 32'h0, 4'h0, 2'h1);
      tk(2);
      chk(pc[3], 32'h2);
      bus(1'b0, OFS_QUEUE_BASE + OFS_QUEUE_STRIDE, 32'h0);
      chk(r, 32'h8000_0006);
      bus(1'b0, OFS_QUEUE_BASE + OFS_QUEUE_STRIDE, 32'h0);
      chk(r, 32'h8000_0003);
      bus(1'b0, OFS_QUEUE_BASE + OFS_QUEUE_STRIDE, 32'h0);
      chk(r[31], 1'b0);
      // five codes into a four-deep queue: the last is dropped without an event
      for (int i = 0; i < 5; i++) begin
         m.send(SRC_TELECOM_SERIAL_PORT, 1'b1, 3'h1, 32'h0, 4'h0, 2'h1);
      end
      tk(2);
      chk(pc[3], 32'h6);
      $display("test telecom_serial_port done");
   endtask
   task automatic t_link();
      @(posedge clk);
      lact <= 1'b1;
      m.send(SRC_LINK, 1'b1, 3'h5);
      #1;
      chk({lrv, lst}, 4'hD);
      bus(1'b1, OFS_LINK_CTRL, 32'h1);
      m.send(SRC_LINK, 1'b0, 3'h4);
      tk(2);
      chk({pc[4][3:0], pc[5][3:0]}, 8'h11);
      @(posedge clk);
      lact <= 1'b0;
      m.send(SRC_LINK, 1'b1, 3'h5);
      #1;
      chk(lrv, 1'b0);
      $display("test link done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_app();
      t_quiet();
      t_dsp();
      t_dma();
      t_serial_interconnect_port();
      t_telecom_serial_port();
      t_link();
      bus(1'b0, 8'h24, 32'h0);
      chk(r, 32'h0);
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
